//--- design/imu_pkg.sv
// Shared constants, types and helpers for the inertial sample readout block
package imu_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_HZ       = 20_000_000;
   localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
   localparam int SAMPLE_SPS   = 2048;
   localparam int SAMPLE_CYC   = CLK_HZ / SAMPLE_SPS;
   localparam int STARTUP_MS   = 290;
   localparam int STARTUP_CYC  = STARTUP_MS * (CLK_HZ / 1000);
   localparam int RECOVER_MS   = 222;
   localparam int RECOVER_CYC  = RECOVER_MS * (CLK_HZ / 1000);
   localparam int RST_INIT_US  = 10;
   localparam int RST_INIT_CYC = (RST_INIT_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int SYNC_DR_US   = 636;
   localparam int SYNC_DR_CYC  = SYNC_DR_US * CYC_PER_US;
   localparam int DR_HIGH_US   = 20;
   localparam int DR_HIGH_CYC  = DR_HIGH_US * CYC_PER_US;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and layout
   localparam int CNT_W       = 23;
   localparam int PHASE_W     = 14;
   localparam int RST_CNT_W   = 8;
   localparam int DR_CNT_W    = 9;
   localparam int WORD_W      = 16;
   localparam int OUT_WORDS   = 9;
   localparam int BURST_WORDS = 10;
   localparam int FIFO_DEPTH  = 16;
   localparam int DIAG_IDX    = 0;
   localparam int RATE_IDX    = 1;
   localparam int ACCEL_IDX   = 4;
   localparam int TEMP_IDX    = 7;
   localparam int COUNT_IDX   = 8;
   localparam int DIAG_UNDERRUN_BIT  = 0;
   localparam int DIAG_SYNC_DROP_BIT = 1;
   localparam logic [6:0]  BURST_CMD = 7'h3E;
   localparam logic [1:0]  SYNC_EXT  = 2'h1;
   localparam logic [15:0] WORD_RST  = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef logic [WORD_W-1:0] word_t;

   typedef struct packed {
      word_t        temp;
      word_t [2:0]  accel;
      word_t [2:0]  rate;
   } raw_sample_s;

   typedef struct packed {
      logic rst_n;
      logic sync;
      logic sclk;
      logic cs_n;
      logic mosi;
   } pin_s;

   typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_HELD, ST_RECOVER} life_e;

   ////////////////////////////////////////////////////////////////////////////
   // Byte sum over the output words
   function automatic word_t burst_checksum(input word_t [OUT_WORDS-1:0] w);
      word_t s;
      s = '0;
      for (int i = 0; i < OUT_WORDS; i++) begin
         s = s + word_t'(w[i][15:8]) + word_t'(w[i][7:0]);
      end
      return s;
   endfunction

endpackage

//--- design/sample_fifo.sv
// Word FIFO between the burst loader and the serial shifter
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_reg;
   logic [AW:0]      wr_next;
   logic [AW:0]      rd_reg;
   logic [AW:0]      rd_next;
   logic             push;
   logic             pop;

   always_comb begin
      in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
      out_valid = wr_reg != rd_reg;
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      out_data  = mem[rd_reg[AW-1:0]];
      wr_next   = flush ? '0 : wr_reg + (AW+1)'(push);
      rd_next   = flush ? '0 : rd_reg + (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   always_ff @(posedge clk) begin
      if (push && !flush) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

endmodule

//--- design/imu_sample_core.sv
// Sample pacing, reset recovery, sync timing and serial readout of the sensor
`timescale 1ns/1ps
// How it works
// - Internal timer, held at zero outside run and in sync mode, makes a sample set at 2048 per second.
// - Each completed sample cycle drives a high pulse on the sample-done output.
// - Serial slave in polarity 1 phase 1, 16-bit words, most significant bit first.
// - First sample after power-up appears no later than 290 ms.
// - After reset pin release, sample-done pulses resume within 222 ms.
// - Reset recovery only counts once the power-up start-up has finished.
// - Sync mode 01 samples on external sync edges, 0.8 to 2000 Hz, slower still works.
// - In sync mode, sample-done rises 636 us after the starting sync edge.
// - Burst read words follow back to back with no stall.
module imu_sample_core
   import imu_pkg::*;
#(
   parameter int SAMPLE_PERIOD = SAMPLE_CYC,
   parameter int STARTUP_LEN   = STARTUP_CYC,
   parameter int RECOVER_LEN   = RECOVER_CYC,
   parameter int SYNC_DELAY    = SYNC_DR_CYC
) (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // Host control pins
   input  wire logic        RESET_PIN_N,
   input  wire logic        SYNC_IN,
   input  wire logic [1:0]  SYNC_MODE_SELECT,
   // Serial port
   input  wire logic        SCLK,
   input  wire logic        CS_N,
   input  wire logic        MOSI,
   output logic             MISO,
   // Sensor front end
   input  wire raw_sample_s RAW_SAMPLE,
   // Sample status
   output logic             SAMPLE_DONE_STROBE
);

   pin_s                         meta_reg, pins_reg, prev_reg;
   life_e                        life_reg, life_next;
   logic [CNT_W-1:0]             life_cnt_reg, life_cnt_next;
   logic [RST_CNT_W-1:0]         rst_low_reg, rst_low_next;
   logic [PHASE_W-1:0]           phase_reg, phase_next;
   logic [PHASE_W-1:0]           slot_cnt_reg [2];
   logic [PHASE_W-1:0]           slot_cnt_next [2];
   logic [1:0]                   slot_busy_reg, slot_busy_next;
   logic                         dr_reg, dr_next;
   logic [DR_CNT_W-1:0]          dr_cnt_reg, dr_cnt_next;
   word_t [OUT_WORDS-1:0]        out_reg, out_next;
   word_t                        diag_reg, diag_next;
   word_t                        smpl_cnt_reg, smpl_cnt_next;
   logic                         ext, run, rst_init, start_done, int_tick;
   logic                         slot_tick, sync_edge, sync_drop, sample_done;
   logic [3:0]                   bit_cnt_reg, bit_cnt_next;
   word_t                        rx_reg, rx_next, tx_reg, tx_next, pend_reg, pend_next;
   word_t                        shift_word, load_word;
   logic                         miso_reg, miso_next, burst_reg, burst_next;
   logic                         loading_reg, loading_next;
   logic [3:0]                   load_idx_reg, load_idx_next;
   logic [5:0]                   rd_idx;
   logic                         cs_act, sclk_rise, sclk_fall, word_done, underrun;
   logic                         fifo_in_ready, fifo_out_valid, fifo_pop;
   word_t                        fifo_out_data;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         meta_reg <= '1;
         pins_reg <= '1;
         prev_reg <= '1;
      end else begin
         meta_reg <= '{RESET_PIN_N, SYNC_IN, SCLK, CS_N, MOSI};
         pins_reg <= meta_reg;
         prev_reg <= pins_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Life cycle, sample pacing and sample-done pulse
   always_comb begin
      ext        = SYNC_MODE_SELECT == SYNC_EXT;
      run        = life_reg == ST_RUN;
      rst_init   = rst_low_reg == RST_CNT_W'(RST_INIT_CYC);
      start_done = 1'b0;
      life_next  = life_reg;
      life_cnt_next = (life_reg == ST_BOOT || life_reg == ST_RECOVER) ?
                      CNT_W'(life_cnt_reg + 1'b1) : '0;
      // Short low pulses are not taken as a reset
      rst_low_next = pins_reg.rst_n ? '0 : (rst_init ? rst_low_reg : RST_CNT_W'(rst_low_reg + 1'b1));
      case (life_reg)
         ST_BOOT: begin
            // Reset pin is not honoured until start-up is complete
            if (life_cnt_reg == CNT_W'(STARTUP_LEN - 1)) begin
               start_done = 1'b1;
               life_next  = ST_RUN;
            end
         end
         ST_RUN:  if (rst_init) life_next = ST_HELD;
         ST_HELD: if (pins_reg.rst_n) life_next = ST_RECOVER;
         ST_RECOVER: begin
            if (rst_init) begin
               life_next = ST_HELD;
            end else if (life_cnt_reg == CNT_W'(RECOVER_LEN - 1)) begin
               start_done = 1'b1;
               life_next  = ST_RUN;
            end
         end
         default: life_next = ST_BOOT;
      endcase
      // Internal sample timer
      int_tick = run && !ext && phase_reg == PHASE_W'(SAMPLE_PERIOD - 1);
      phase_next = (run && !ext && !int_tick) ? PHASE_W'(phase_reg + 1'b1) : '0;
      // External sync: two delay slots so edges may overlap the latency
      sync_edge = run && ext && pins_reg.sync && !prev_reg.sync;
      slot_tick = 1'b0;
      sync_drop = 1'b0;
      for (int i = 0; i < 2; i++) begin
         slot_cnt_next[i]  = PHASE_W'(slot_cnt_reg[i] + 1'b1);
         slot_busy_next[i] = slot_busy_reg[i] && run && ext;
         if (slot_busy_reg[i] && slot_cnt_reg[i] == PHASE_W'(SYNC_DELAY - 1)) begin
            slot_tick         = 1'b1;
            slot_busy_next[i] = 1'b0;
         end
      end
      if (sync_edge) begin
         if (!slot_busy_next[0]) begin
            slot_busy_next[0] = 1'b1;
            slot_cnt_next[0]  = '0;
         end else if (!slot_busy_next[1]) begin
            slot_busy_next[1] = 1'b1;
            slot_cnt_next[1]  = '0;
         end else begin
            sync_drop = 1'b1;
         end
      end
      sample_done = start_done || int_tick || slot_tick;
      // Sample-done pulse
      dr_next     = sample_done || (dr_reg && dr_cnt_reg != '0 && life_reg != ST_HELD);
      dr_cnt_next = sample_done ? DR_CNT_W'(DR_HIGH_CYC - 1) : dr_cnt_reg - DR_CNT_W'(dr_cnt_reg != '0);
      // Output word capture; new events win over the capture clear
      diag_next = diag_reg;
      diag_next[DIAG_UNDERRUN_BIT]  = diag_reg[DIAG_UNDERRUN_BIT] || underrun;
      diag_next[DIAG_SYNC_DROP_BIT] = diag_reg[DIAG_SYNC_DROP_BIT] || sync_drop;
      out_next      = out_reg;
      smpl_cnt_next = smpl_cnt_reg;
      if (sample_done) begin
         smpl_cnt_next = word_t'(smpl_cnt_reg + 1'b1);
         out_next[DIAG_IDX] = diag_next;
         for (int a = 0; a < 3; a++) begin
            out_next[RATE_IDX + a]  = RAW_SAMPLE.rate[a];
            out_next[ACCEL_IDX + a] = RAW_SAMPLE.accel[a];
         end
         out_next[TEMP_IDX]  = RAW_SAMPLE.temp;
         out_next[COUNT_IDX] = smpl_cnt_next;
         diag_next = '0;
         diag_next[DIAG_UNDERRUN_BIT]  = underrun;
         diag_next[DIAG_SYNC_DROP_BIT] = sync_drop;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         life_reg      <= ST_BOOT;
         life_cnt_reg  <= '0;
         rst_low_reg   <= '0;
         phase_reg     <= '0;
         slot_cnt_reg  <= '{default: '0};
         slot_busy_reg <= '0;
         dr_reg        <= 1'b0;
         dr_cnt_reg    <= '0;
         out_reg       <= '{default: WORD_RST};
         diag_reg      <= WORD_RST;
         smpl_cnt_reg  <= WORD_RST;
      end else begin
         life_reg      <= life_next;
         life_cnt_reg  <= life_cnt_next;
         rst_low_reg   <= rst_low_next;
         phase_reg     <= phase_next;
         slot_cnt_reg  <= slot_cnt_next;
         slot_busy_reg <= slot_busy_next;
         dr_reg        <= dr_next;
         dr_cnt_reg    <= dr_cnt_next;
         out_reg       <= out_next;
         diag_reg      <= diag_next;
         smpl_cnt_reg  <= smpl_cnt_next;
      end
   end
   assign SAMPLE_DONE_STROBE = dr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave and burst loader
   always_comb begin
      cs_act    = !pins_reg.cs_n;
      sclk_rise = pins_reg.sclk && !prev_reg.sclk;
      sclk_fall = !pins_reg.sclk && prev_reg.sclk;
      bit_cnt_next  = bit_cnt_reg;
      rx_next       = rx_reg;
      tx_next       = tx_reg;
      pend_next     = pend_reg;
      miso_next     = miso_reg;
      burst_next    = burst_reg;
      loading_next  = loading_reg;
      load_idx_next = load_idx_reg;
      shift_word    = pend_reg;
      fifo_pop      = 1'b0;
      underrun      = 1'b0;
      word_done     = 1'b0;
      rd_idx        = '0;
      load_word     = (load_idx_reg == 4'(BURST_WORDS - 1)) ? burst_checksum(out_reg) :
                      out_reg[load_idx_reg];
      if (loading_reg && fifo_in_ready) begin
         load_idx_next = 4'(load_idx_reg + 1'b1);
         loading_next  = load_idx_reg != 4'(BURST_WORDS - 1);
      end
      if (!cs_act) begin
         bit_cnt_next = '0;
         burst_next   = 1'b0;
         loading_next = 1'b0;
      end else begin
         if (sclk_fall) begin
            if (bit_cnt_reg != '0) begin
               shift_word = tx_reg;
            end else if (burst_reg) begin
               fifo_pop   = fifo_out_valid;
               underrun   = !fifo_out_valid;
               shift_word = fifo_out_valid ? fifo_out_data : '0;
            end
            miso_next = shift_word[WORD_W-1];
            tx_next   = {shift_word[WORD_W-2:0], 1'b0};
         end
         if (sclk_rise) begin
            rx_next      = {rx_reg[WORD_W-2:0], pins_reg.mosi};
            bit_cnt_next = 4'(bit_cnt_reg + 1'b1);
            word_done    = bit_cnt_reg == 4'hF;
         end
         if (word_done && !burst_reg && !rx_next[WORD_W-1]) begin
            if (rx_next[14:8] == BURST_CMD) begin
               burst_next    = 1'b1;
               loading_next  = 1'b1;
               load_idx_next = '0;
               pend_next     = '0;
            end else begin
               rd_idx    = rx_next[14:9];
               pend_next = (rd_idx < 6'(OUT_WORDS)) ? out_reg[rd_idx] : '0;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         bit_cnt_reg  <= '0;
         rx_reg       <= WORD_RST;
         tx_reg       <= WORD_RST;
         pend_reg     <= WORD_RST;
         miso_reg     <= 1'b0;
         burst_reg    <= 1'b0;
         loading_reg  <= 1'b0;
         load_idx_reg <= '0;
      end else begin
         bit_cnt_reg  <= bit_cnt_next;
         rx_reg       <= rx_next;
         tx_reg       <= tx_next;
         pend_reg     <= pend_next;
         miso_reg     <= miso_next;
         burst_reg    <= burst_next;
         loading_reg  <= loading_next;
         load_idx_reg <= load_idx_next;
      end
   end
   assign MISO = miso_reg;
   sample_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .flush     (!cs_act),
      .in_valid  (loading_reg),
      .in_data   (load_word),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [PHASE_W-1:0] gap_reg, edge_age_reg;
   logic [CNT_W-1:0]   since_rst_reg;
   logic               last_int_reg;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         gap_reg       <= '0;
         edge_age_reg  <= '0;
         since_rst_reg <= '0;
         last_int_reg  <= 1'b0;
      end else begin
         gap_reg       <= sample_done ? '0 : (&gap_reg ? gap_reg : PHASE_W'(gap_reg + 1'b1));
         edge_age_reg  <= sync_edge ? '0 : (&edge_age_reg ? edge_age_reg : PHASE_W'(edge_age_reg + 1'b1));
         since_rst_reg <= &since_rst_reg ? since_rst_reg : CNT_W'(since_rst_reg + 1'b1);
         last_int_reg  <= sample_done ? int_tick : last_int_reg;
      end
   end

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   chk_internal_rate: assert property (int_tick && last_int_reg |-> gap_reg == PHASE_W'(SAMPLE_PERIOD - 1))
      else $error("internal sample period wrong");
   chk_done_pulse: assert property (sample_done |=> SAMPLE_DONE_STROBE [*2])
      else $error("sample-done pulse missing");
   chk_msb_first: assert property (cs_act && sclk_fall && bit_cnt_reg == '0 && !burst_reg |=> MISO == $past(pend_reg[15]))
      else $error("first bit is not the word msb");
   chk_boot_time: assert property (life_reg == ST_BOOT |-> since_rst_reg < CNT_W'(STARTUP_LEN))
      else $error("start-up too long");
   chk_boot_ignore: assert property (life_reg == ST_BOOT |=> life_reg != ST_HELD)
      else $error("reset taken during start-up");
   chk_recover_dr: assert property (life_reg == ST_RECOVER ##1 life_reg == ST_RUN |-> ##1 SAMPLE_DONE_STROBE)
      else $error("no pulse after recovery");
   chk_recover_time: assert property ($rose(life_reg == ST_RECOVER) && $past(life_reg) == ST_HELD
                                      |-> life_cnt_reg == '0)
      else $error("recovery count not restarted");
   chk_sync_only: assert property (run && ext && slot_busy_reg == 2'b00 |-> !sample_done)
      else $error("sample without sync edge");
   chk_sync_latency: assert property (slot_tick && ^slot_busy_reg |-> edge_age_reg == PHASE_W'(SYNC_DELAY - 1))
      else $error("sync to sample-done latency wrong");
   chk_burst_fill: assert property (word_done && burst_next && !burst_reg |=> ##[0:2] fifo_out_valid)
      else $error("burst word not ready");

endmodule

//--- bench/host_model.sv
// Host model: serial master, reset pin and sync pin driver
`timescale 1ns/1ps
module host_model (
   // Serial port
   output logic     sclk,
   output logic     cs_n,
   output logic     mosi,
   input  wire logic miso,
   // Control pins
   output logic     reset_n,
   output logic     sync
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
      reset_n = 1'b1;
      sync = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One word, clock idle high, data out on fall, most significant bit first
   task automatic shift(input logic [15:0] tx, output logic [15:0] rx);
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b0;
         mosi = tx[i];
         #200;
         sclk = 1'b1;
         #190;
         rx[i] = miso;
         #10;
      end
   endtask

   // Single word with its own select, then idle stall
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      #13;
      cs_n = 1'b0;
      #200;
      shift(tx, rx);
      #200;
      cs_n = 1'b1;
      mosi = ~mosi;
      #16000;
   endtask

   // Burst command then ten words with no stall
   task automatic burst(output logic [15:0] rx [10]);
      logic [15:0] cmd_rx;
      #13;
      cs_n = 1'b0;
      #200;
      shift(16'h3E00, cmd_rx);
      for (int k = 0; k < 10; k++) begin
         shift(16'h0000, rx[k]);
      end
      #200;
      cs_n = 1'b1;
      mosi = ~mosi;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reset pin low pulse
   task automatic pin_reset(input int ns);
      reset_n = 1'b0;
      #ns;
      reset_n = 1'b1;
   endtask

   // Sync high pulse
   task automatic sync_pulse(input int ns);
      sync = 1'b1;
      #ns;
      sync = 1'b0;
   endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the sample readout core
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
   $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module tb_top
   import imu_pkg::*;
;
   localparam int SP = 500;
   localparam int SU = 2000;
   localparam int RC = 1500;
   localparam int SD = 300;
   logic         sys_clk, sclk, cs_n, mosi, miso, pin_rst_n, sync_in, strobe;
   logic         rst_n = 1'b0;
   logic         strobe_q = 1'b0;
   logic         sync_q = 1'b0;
   logic [1:0]   mode = 2'h0;
   raw_sample_s  raw = '0;
   logic [127:0] rnd;
   logic [15:0]  rx;
   logic [15:0]  ev;
   logic [15:0]  bw [10];
   logic [15:0]  exp_q [$];
   int           err_total = 0;
   int           comparisons = 0;
   int           cyc = 0;
   int           rise_cyc = 0;
   int           n_rise = 0;
   int           high_cnt = 0;
   int           sync_cyc = 0;
   int           r0, r1, nn, sum;
   int           idx [10] = '{1, 2, 3, 4, 5, 6, 7, 9, 0, 0};

   imu_sample_core #(.SAMPLE_PERIOD(SP), .STARTUP_LEN(SU), .RECOVER_LEN(RC), .SYNC_DELAY(SD)) u_imu_sample_core (
      .SYS_CLK(sys_clk), .RST_N(rst_n), .RESET_PIN_N(pin_rst_n), .SYNC_IN(sync_in),
      .SYNC_MODE_SELECT(mode), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso),
      .RAW_SAMPLE(raw), .SAMPLE_DONE_STROBE(strobe));
   host_model u_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .reset_n(pin_rst_n), .sync(sync_in));

   ////////////////////////////////////////////////////////////////////////////
   // Clock, strobe and sync monitor
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      strobe_q <= strobe;
      sync_q <= sync_in;
      if (sync_in && !sync_q) sync_cyc <= cyc;
      if (strobe === 1'b1) high_cnt <= high_cnt + 1;
      if (strobe === 1'b1 && strobe_q !== 1'b1) begin
         rise_cyc <= cyc;
         n_rise <= n_rise + 1;
         high_cnt <= 1;
      end
      if (strobe !== 1'b1 && strobe_q === 1'b1) `CHK(high_cnt, DR_HIGH_CYC)
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference model of the readable words
   function automatic logic [15:0] model_word(int k);
      case (k)
         1, 2, 3: return raw.rate[k-1];
         4, 5, 6: return raw.accel[k-4];
         7:       return raw.temp;
         default: return 16'h0000;
      endcase
   endfunction

   task automatic next_rise(input int lim, output int r);
      int n;
      n = n_rise;
      r = -100000;
      repeat (lim) begin
         @(posedge sys_clk);
         #1;
         if (n_rise != n) begin
            r = rise_cyc;
            break;
         end
      end
   endtask

   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge sys_clk);
      err_total++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h1111));
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      r0 = cyc;
      repeat (300) @(posedge sys_clk);
      u_host_model.pin_reset(12000);
      next_rise(2 * SU, r1);
      `CHK((r1 - r0) inside {[SU : SU + 4]}, 1'b1)
      rnd = {$urandom, $urandom, $urandom, $urandom};
      @(posedge sys_clk);
      raw <= rnd[111:0];
      next_rise(2 * SP, r0);
      next_rise(2 * SP, r1);
      `CHK(r1 - r0, SP)
      foreach (idx[i]) begin
         u_host_model.xfer(16'(idx[i] << 9), rx);
         if (i > 0) begin
            ev = exp_q.pop_front();
            `CHK(rx, ev)
         end
         exp_q.push_back(model_word(idx[i]));
      end
      next_rise(2 * SP, r0);
      u_host_model.pin_reset(5000);
      next_rise(2 * SP, r1);
      `CHK(r1 - r0, SP)
      next_rise(2 * SP, r0);
      nn = n_rise;
      u_host_model.burst(bw);
      sum = 0;
      for (int k = 0; k < 9; k++) begin
         ev = (k == COUNT_IDX) ? 16'(nn) : model_word(k);
         `CHK(bw[k], ev)
         sum += ev[15:8] + ev[7:0];
      end
      `CHK(bw[9], sum[15:0])
      @(posedge sys_clk);
      mode <= SYNC_EXT;
      repeat (3) @(posedge sys_clk);
      nn = n_rise;
      repeat (3 * SP) @(posedge sys_clk);
      `CHK(n_rise, nn)
      repeat (2) begin
         repeat (1000 + $urandom % 3000) @(posedge sys_clk);
         fork
            u_host_model.sync_pulse(25000);
            next_rise(2 * SD, r1);
         join
         `CHK((r1 - sync_cyc) inside {[SD + 2 : SD + 7]}, 1'b1)
      end
      repeat (SP) @(posedge sys_clk);
      nn = n_rise;
      u_host_model.pin_reset(12000);
      r0 = cyc;
      next_rise(2 * RC, r1);
      `CHK(n_rise, nn + 1)
      `CHK((r1 - r0) inside {[RC + 1 : RC + 8]}, 1'b1)
      @(posedge sys_clk);
      mode <= (($urandom % 3) == 0) ? 2'h0 : 2'($urandom % 2 + 2);
      next_rise(2 * SP, r0);
      next_rise(2 * SP, r1);
      `CHK(r1 - r0, SP)
      tally_and_finish();
   end
endmodule
